// ### sawd_pkg.sv
// Shared constants and types of the SAR converter control block
package sawd_pkg;
    localparam logic [7:0] CFG_ADDR = 8'hbc;
    localparam logic [7:0] RES_ADDR = 8'hbe;
    localparam logic [7:0] UPPER_ADDR = 8'hc4;
    localparam logic [7:0] LOWER_ADDR = 8'hc6;
    localparam logic [7:0] CTRL_ADDR = 8'he8;
    localparam logic [7:0] CFG_RST = 8'hf8;
    localparam logic [7:0] RES_RST = 8'h00;
    localparam logic [7:0] UPPER_RST = 8'hff;
    localparam logic [7:0] LOWER_RST = 8'h00;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam int CFG_DIV_LSB = 3;
    localparam int CFG_DIV_W = 5;
    localparam int CFG_GAIN_LSB = 0;
    localparam int CTL_EN = 7;
    localparam int CTL_TM = 6;
    localparam int CTL_DONE = 5;
    localparam int CTL_BUSY = 4;
    localparam int CTL_SRC_LSB = 1;
    localparam int CTL_MATCH = 0;
    localparam logic [2:0] SRC_SOFT = 3'h0;
    localparam logic [2:0] SRC_TIMER3 = 3'h1;
    localparam logic [2:0] SRC_EXT = 3'h2;
    localparam logic [2:0] SRC_TIMER2 = 3'h3;
    localparam logic [1:0] TRACK_LAST = 2'h2;
    localparam logic [2:0] SAR_MSB_IDX = 3'h7;
    localparam logic [7:0] SAR_FIRST_TRIAL = 8'h80;
    localparam logic [3:0] CONV_TICKS = 4'h8;
    localparam logic [1:0] RST_SYNC_IDLE = 2'h0;
    // Start pin idles high, so no false rise follows reset
    localparam logic [2:0] PIN_SYNC_RST = 3'h7;
    localparam logic [7:0] RDATA_RST = 8'h00;
    localparam logic [4:0] DIV_CNT_RST = 5'h00;

    typedef enum logic [1:0] {
        GAIN_HALF = 2'h0,
        GAIN_ONE = 2'h1,
        GAIN_TWO = 2'h2,
        GAIN_FOUR = 2'h3
    } sawd_gain_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_TRACK = 2'h1,
        ST_CONV = 2'h3
    } sawd_state_e;
endpackage : sawd_pkg

// ### sawd_win_if.sv
// Result and limits passed to the window comparator
`timescale 1ns/1ps
`default_nettype none
interface sawd_win_if;
    logic [7:0] code;
    logic [7:0] lower;
    logic [7:0] upper;
    logic diff;
    logic match;
    modport ctrl (output code, output lower, output upper, output diff,
                  input match);
    modport cmp (input code, input lower, input upper, input diff,
                 output match);
endinterface : sawd_win_if
`default_nettype wire

// ### sawd_clkdiv.sv
// Conversion clock divider producing one tick per SAR period
`timescale 1ns/1ps
`default_nettype none
module sawd_clkdiv (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic restart,
    input wire logic [4:0] div,
    output logic tick
);
    typedef struct packed {
        logic [4:0] cnt;
    } sawd_div_s;

    sawd_div_s st;
    sawd_div_s next_st;

    // Greater-or-equal guards against a divider shrunk mid-count
    assign tick = !restart && (st.cnt >= div);

    always_comb begin
        next_st = st;
        if (restart || tick) begin
            next_st.cnt = sawd_pkg::DIV_CNT_RST;
        end else begin
            next_st.cnt = st.cnt + 5'h01;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '{cnt: sawd_pkg::DIV_CNT_RST};
        end else begin
            st <= next_st;
        end
    end

    tick_spacing_a: assert property (@(posedge clk) disable iff (!rst_n)
        (tick && !restart && div != 5'h00) |=> !tick)
        else $error("divider ticked on consecutive cycles");
endmodule : sawd_clkdiv
`default_nettype wire

// ### sawd_window.sv
// Window comparator over signed or unsigned codes
`timescale 1ns/1ps
`default_nettype none
module sawd_window (
    sawd_win_if.cmp w
);
    function automatic logic less(input logic [7:0] a,
                                  input logic [7:0] b,
                                  input logic sgn);
        less = sgn ? ($signed(a) < $signed(b)) : (a < b);
    endfunction : less

    logic below_lower;
    logic above_upper;
    logic inverted;

    assign below_lower = less(w.code, w.lower, w.diff);
    assign above_upper = less(w.upper, w.code, w.diff);
    assign inverted = less(w.upper, w.lower, w.diff);

    // inside or outside by limit order
    assign w.match = inverted ? (above_upper && below_lower)
                              : (below_lower || above_upper);
endmodule : sawd_window
`default_nettype wire

// ### sawd_adc_ctrl.sv
// Control, registers and SAR sequencer of the 8-bit converter
`timescale 1ns/1ps
`default_nettype none
module sawd_adc_ctrl (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic timer3_overflow,
    input wire logic timer2_overflow,
    input wire logic primary_converter_busy_bit,
    input wire logic external_convert_start,
    input wire logic channel_is_differential,
    input wire logic sar_compare,
    output logic [7:0] sar_trial,
    output logic [1:0] amplifier_gain_select,
    output logic converter_power_on,
    output logic track_enable,
    output logic conversion_done_flag,
    output logic window_match_flag
);
    typedef struct packed {
        sawd_pkg::sawd_state_e fsm;
        logic [4:0] div;
        sawd_pkg::sawd_gain_e gain;
        logic enable;
        logic tmode;
        logic done;
        logic [2:0] src;
        logic match;
        logic [7:0] result;
        logic [7:0] upper;
        logic [7:0] lower;
        logic [7:0] trial;
        logic [2:0] bit_idx;
        logic [1:0] trk_cnt;
        logic [2:0] pin_sync;
        logic pin_level;
        logic [7:0] rdata;
        logic track;
        logic power;
    } sawd_ctrl_s;

    localparam sawd_ctrl_s ST_RST = '{
        fsm: sawd_pkg::ST_IDLE,
        div: sawd_pkg::CFG_RST[7:3],
        gain: sawd_pkg::sawd_gain_e'(sawd_pkg::CFG_RST[1:0]),
        enable: sawd_pkg::CTRL_RST[7],
        tmode: sawd_pkg::CTRL_RST[6],
        done: sawd_pkg::CTRL_RST[5],
        src: sawd_pkg::CTRL_RST[3:1],
        match: sawd_pkg::CTRL_RST[0],
        result: sawd_pkg::RES_RST,
        upper: sawd_pkg::UPPER_RST,
        lower: sawd_pkg::LOWER_RST,
        trial: sawd_pkg::SAR_FIRST_TRIAL,
        bit_idx: sawd_pkg::SAR_MSB_IDX,
        trk_cnt: 2'h0,
        pin_sync: sawd_pkg::PIN_SYNC_RST,
        pin_level: sawd_pkg::PIN_SYNC_RST[2],
        rdata: sawd_pkg::RDATA_RST,
        track: 1'b0,
        power: 1'b0
    };

    sawd_ctrl_s st;
    sawd_ctrl_s next_st;
    logic [1:0] rst_pipe;
    logic rst_n_sync;
    logic sar_tick;
    logic busy_now;
    logic [7:0] decided;
    logic [7:0] final_code;
    logic wr_ctl;
    logic pin_rise;
    logic trig;
    logic lp_pin_mode;
    logic [3:0] conv_ticks;

    sawd_win_if win ();

    // Reset asserts at once and leaves in step with the clock
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rst_pipe <= sawd_pkg::RST_SYNC_IDLE;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_n_sync = rst_pipe[1];

    assign busy_now = (st.fsm != sawd_pkg::ST_IDLE);
    assign wr_ctl = sfr_wr && (sfr_addr == sawd_pkg::CTRL_ADDR);

    sawd_clkdiv u_div (
        .clk(core_clk),
        .rst_n(rst_n_sync),
        .restart(st.fsm == sawd_pkg::ST_IDLE),
        .div(st.div),
        .tick(sar_tick)
    );

    // Comparator outcome for the bit under test
    assign decided = sar_compare ? st.trial
                                 : (st.trial & ~(8'h01 << st.bit_idx));
    assign final_code = channel_is_differential
                        ? {~decided[7], decided[6:0]} : decided;

    // comparator sees the code being finished
    assign win.code = final_code;
    assign win.lower = st.lower;
    assign win.upper = st.upper;
    assign win.diff = channel_is_differential;

    sawd_window u_win (
        .w(win.cmp)
    );

    always_comb begin
        next_st = st;
        trig = 1'b0;
        // Pin level changes only when stages two and three agree
        next_st.pin_sync = {st.pin_sync[1:0], external_convert_start};
        if (st.pin_sync[1] == st.pin_sync[2]) begin
            next_st.pin_level = st.pin_sync[2];
        end
        pin_rise = next_st.pin_level && !st.pin_level;

        if (sfr_wr && (sfr_addr == sawd_pkg::CFG_ADDR)) begin
            next_st.div = sfr_wdata[sawd_pkg::CFG_DIV_LSB +: 5];
            next_st.gain = sawd_pkg::sawd_gain_e'(
                sfr_wdata[sawd_pkg::CFG_GAIN_LSB +: 2]);
        end
        if (sfr_wr && (sfr_addr == sawd_pkg::RES_ADDR)) begin
            next_st.result = sfr_wdata;
        end
        if (sfr_wr && (sfr_addr == sawd_pkg::UPPER_ADDR)) begin
            next_st.upper = sfr_wdata;
        end
        if (sfr_wr && (sfr_addr == sawd_pkg::LOWER_ADDR)) begin
            next_st.lower = sfr_wdata;
        end
        if (wr_ctl) begin
            next_st.enable = sfr_wdata[sawd_pkg::CTL_EN];
            next_st.tmode = sfr_wdata[sawd_pkg::CTL_TM];
            next_st.src = sfr_wdata[sawd_pkg::CTL_SRC_LSB +: 3];
            next_st.done = sfr_wdata[sawd_pkg::CTL_DONE];
            next_st.match = sfr_wdata[sawd_pkg::CTL_MATCH];
        end

        if (next_st.src[2]) begin
            trig = primary_converter_busy_bit;
        end else begin
            unique case (next_st.src)
                // busy write starts only with 000
                sawd_pkg::SRC_SOFT:
                    trig = wr_ctl && sfr_wdata[sawd_pkg::CTL_BUSY];
                sawd_pkg::SRC_TIMER3: trig = timer3_overflow;
                sawd_pkg::SRC_EXT: trig = pin_rise;
                sawd_pkg::SRC_TIMER2: trig = timer2_overflow;
            endcase
        end
        lp_pin_mode = next_st.tmode && (next_st.src == sawd_pkg::SRC_EXT);

        unique case (st.fsm)
            sawd_pkg::ST_IDLE: begin
                if (next_st.enable && trig) begin
                    if (next_st.tmode && !lp_pin_mode) begin
                        next_st.fsm = sawd_pkg::ST_TRACK;
                        next_st.trk_cnt = 2'h0;
                    end else begin
                        next_st.fsm = sawd_pkg::ST_CONV;
                        next_st.bit_idx = sawd_pkg::SAR_MSB_IDX;
                        next_st.trial = sawd_pkg::SAR_FIRST_TRIAL;
                    end
                end
            end
            sawd_pkg::ST_TRACK: begin
                if (sar_tick) begin
                    if (st.trk_cnt == sawd_pkg::TRACK_LAST) begin
                        next_st.fsm = sawd_pkg::ST_CONV;
                        next_st.bit_idx = sawd_pkg::SAR_MSB_IDX;
                        next_st.trial = sawd_pkg::SAR_FIRST_TRIAL;
                    end else begin
                        next_st.trk_cnt = st.trk_cnt + 2'h1;
                    end
                end
            end
            sawd_pkg::ST_CONV: begin
                if (sar_tick) begin
                    if (st.bit_idx == 3'h0) begin
                        next_st.fsm = sawd_pkg::ST_IDLE;
                        next_st.trial = decided;
                        next_st.result = final_code;
                        next_st.done = 1'b1;
                        next_st.match = next_st.match || win.match;
                    end else begin
                        next_st.bit_idx = st.bit_idx - 3'h1;
                        next_st.trial = decided
                            | (8'h01 << (st.bit_idx - 3'h1));
                    end
                end
            end
            default: next_st.fsm = sawd_pkg::ST_IDLE;
        endcase

        if (!next_st.enable) begin
            next_st.fsm = sawd_pkg::ST_IDLE;
        end
        next_st.power = next_st.enable;
        next_st.track = next_st.enable
            && ((next_st.fsm == sawd_pkg::ST_TRACK)
             || ((next_st.fsm == sawd_pkg::ST_IDLE)
              && (!next_st.tmode
               || (lp_pin_mode && !next_st.pin_level))));

        if (sfr_rd) begin
            unique case (sfr_addr)
                sawd_pkg::CFG_ADDR:
                    next_st.rdata = {st.div, 1'b0, st.gain};
                sawd_pkg::RES_ADDR: next_st.rdata = st.result;
                sawd_pkg::UPPER_ADDR: next_st.rdata = st.upper;
                sawd_pkg::LOWER_ADDR: next_st.rdata = st.lower;
                sawd_pkg::CTRL_ADDR:
                    next_st.rdata = {st.enable, st.tmode, st.done,
                                     busy_now, st.src, st.match};
                default: next_st.rdata = sawd_pkg::RDATA_RST;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            st <= ST_RST;
        end else begin
            st <= next_st;
        end
    end

    assign sfr_rdata = st.rdata;
    assign sar_trial = st.trial;
    assign amplifier_gain_select = st.gain;
    assign converter_power_on = st.power;
    assign track_enable = st.track;
    assign conversion_done_flag = st.done;
    assign window_match_flag = st.match;

    // Helper counter of SAR ticks seen in one conversion
    always_ff @(posedge core_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            conv_ticks <= 4'h0;
        end else if (st.fsm == sawd_pkg::ST_CONV) begin
            conv_ticks <= conv_ticks + {3'h0, sar_tick};
        end else begin
            conv_ticks <= 4'h0;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n_sync);

    // Busy falling while still powered is a finished conversion, not an abort
    sequence s_conv_end;
        $fell(busy_now) && converter_power_on;
    endsequence
    sequence s_track_last;
        st.fsm == sawd_pkg::ST_TRACK && sar_tick
            && st.trk_cnt == 2'h2 && !sfr_wr;
    endsequence

    gain_write_a: assert property (
        (sfr_wr && sfr_addr == sawd_pkg::CFG_ADDR)
        |=> amplifier_gain_select == $past(sfr_wdata[1:0]))
        else $error("gain field not taken");
    cfg_bit2_a: assert property (
        (sfr_rd && sfr_addr == sawd_pkg::CFG_ADDR) |=> !sfr_rdata[2])
        else $error("unused config bit read nonzero");
    shutdown_hold_a: assert property (
        !converter_power_on |-> !busy_now && !track_enable)
        else $error("converter active while disabled");
    normal_track_a: assert property (
        (converter_power_on && !st.tmode) |-> track_enable == !busy_now)
        else $error("normal tracking wrong");
    done_on_fall_a: assert property (
        s_conv_end |-> conversion_done_flag)
        else $error("done flag not set at busy fall");
    busy_source_a: assert property (
        (!busy_now && wr_ctl && sfr_wdata[4] && sfr_wdata[3:1] != 3'h0
         && sfr_wdata[3:1] != 3'h2 && !timer3_overflow
         && !timer2_overflow && !primary_converter_busy_bit)
        |=> !busy_now)
        else $error("busy write started other source");
    lp_track_len_a: assert property (
        s_track_last |=> st.fsm == sawd_pkg::ST_CONV && sar_trial == 8'h80)
        else $error("tracking did not end after three ticks");
    conv_len_a: assert property (
        s_conv_end |-> conv_ticks == 4'h8)
        else $error("conversion not eight SAR clocks");
    match_sticky_a: assert property (
        (window_match_flag && !(wr_ctl && !sfr_wdata[0]))
        |=> window_match_flag)
        else $error("match flag dropped without clear");
    single_window_a: assert property (
        (!win.diff && st.lower == 8'h20 && st.upper == 8'h10)
        |-> win.match == (win.code > 8'h10 && win.code < 8'h20))
        else $error("single-ended window wrong");
    diff_window_a: assert property (
        (win.diff && st.lower == 8'h10 && st.upper == 8'hff)
        |-> win.match == (win.code < 8'h10))
        else $error("differential window wrong");
    result_flags_a: assert property (
        s_conv_end |-> st.result == $past(win.code)
            && (window_match_flag || !$past(win.match)))
        else $error("result and match not together");
endmodule : sawd_adc_ctrl
`default_nettype wire

// ### sawd_analog_model.sv
// Track-and-hold and comparator model at the converter's analog side
`timescale 1ns/1ps
`default_nettype none
module sawd_analog_model (
    input wire logic clk,
    input wire logic [7:0] level,
    input wire logic power_on,
    input wire logic track,
    input wire logic [7:0] trial,
    output logic compare
);
    logic [7:0] held;
    logic flip = 1'b0;
    // Samples only while tracking, so a skipped track phase gives a stale code
    always @(posedge clk) begin
        flip <= ~flip;
        if (track) begin
            held <= level;
        end
    end
    // Unpowered comparator output is noise, never a stable answer
    assign compare = power_on ? (trial <= held) : flip;
endmodule : sawd_analog_model
`default_nettype wire

// ### test_sar_adc_control_window_detect.sv
// Self-checking bench for the SAR converter control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fails++; \
    $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module test_sar_adc_control_window_detect;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic t3 = 1'b0;
    logic t2 = 1'b0;
    logic pbusy = 1'b0;
    logic pin = 1'b1;
    logic diff = 1'b0;
    logic [7:0] level = 8'h00;
    logic [7:0] sfr_rdata;
    logic [7:0] sar_trial;
    logic [1:0] gain;
    logic sar_compare;
    logic power_on;
    logic track;
    logic done;
    logic match;
    int fails = 0;
    int cmp_count = 0;
    int n;
    int k;
    logic [10:0] d_t = 11'b01111000000;
    logic [10:0] m_t = 11'b11001001001;
    logic [7:0] lo_t [11] = '{8'h20, 8'h20, 8'h20, 8'h10, 8'h10, 8'h00,
        8'h10, 8'h10, 8'h10, 8'h10, 8'h10};
    logic [7:0] up_t [11] = '{8'h10, 8'h10, 8'h10, 8'h20, 8'h20, 8'hff,
        8'hff, 8'hff, 8'hff, 8'hff, 8'h20};
    logic [7:0] lv_t [11] = '{8'h15, 8'h10, 8'h20, 8'h05, 8'h20, 8'hff,
        8'h80, 8'h7f, 8'h90, 8'h8f, 8'h21};

    sawd_adc_ctrl u_sawd_adc_ctrl (
        .core_clk(core_clk), .rstn(rstn), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .timer3_overflow(t3),
        .timer2_overflow(t2), .primary_converter_busy_bit(pbusy),
        .external_convert_start(pin), .channel_is_differential(diff),
        .sar_compare(sar_compare), .sar_trial(sar_trial),
        .amplifier_gain_select(gain), .converter_power_on(power_on),
        .track_enable(track), .conversion_done_flag(done),
        .window_match_flag(match)
    );

    sawd_analog_model u_sawd_analog_model (
        .clk(core_clk), .level(level), .power_on(power_on),
        .track(track), .trial(sar_trial), .compare(sar_compare)
    );

    always #2.5 core_clk = ~core_clk;

    task automatic report_and_stop();
        if (fails == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge core_clk);
        sfr_wr = 1'b0;
    endtask : wr

    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        @(negedge core_clk);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge core_clk);
        sfr_rd = 1'b0;
        `CHK(sfr_rdata, e)
    endtask : rdchk

    // Kinds: 1 timer 3, 2 pin, 3 timer 2, 4 other converter
    task automatic fire(input int kind, input logic lp_pin);
        @(negedge core_clk);
        case (kind)
            1: t3 = 1'b1;
            3: t2 = 1'b1;
            4: pbusy = 1'b1;
            default: begin
                pin = 1'b0;
                repeat (6) @(negedge core_clk);
                if (lp_pin) `CHK(track, 1'b1)
                pin = 1'b1;
            end
        endcase
        @(negedge core_clk);
        {t3, t2, pbusy} = 3'b000;
    endtask : fire

    // Bounded wait; counts edges from the start edge
    task automatic wait_done(output int cnt);
        cnt = 0;
        while (done !== 1'b1 && cnt < 400) begin
            @(negedge core_clk);
            cnt++;
        end
    endtask : wait_done

    initial begin
        #100us;
        fails++;
        report_and_stop();
    end

    initial begin
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
        rstn = 1'b1;
        repeat (3) @(posedge core_clk);
        rdchk(sawd_pkg::CFG_ADDR, sawd_pkg::CFG_RST);
        rdchk(sawd_pkg::RES_ADDR, sawd_pkg::RES_RST);
        rdchk(sawd_pkg::UPPER_ADDR, sawd_pkg::UPPER_RST);
        rdchk(sawd_pkg::LOWER_ADDR, sawd_pkg::LOWER_RST);
        rdchk(sawd_pkg::CTRL_ADDR, sawd_pkg::CTRL_RST);
        rdchk(8'h00, 8'h00);
        `CHK(power_on, 1'b0)
        for (int g = 0; g < 4; g++) begin
            wr(sawd_pkg::CFG_ADDR, 8'hfc | 8'(g));
            rdchk(sawd_pkg::CFG_ADDR, 8'hf8 | 8'(g));
            `CHK(gain, 2'(g))
        end
        wr(sawd_pkg::RES_ADDR, 8'h5a);
        rdchk(sawd_pkg::RES_ADDR, 8'h5a);
        wr(sawd_pkg::CFG_ADDR, 8'h00);
        level = 8'h5c;
        wr(sawd_pkg::CTRL_ADDR, 8'h80);
        `CHK(track, 1'b1)
        wr(sawd_pkg::CTRL_ADDR, 8'h90);
        `CHK(track, 1'b0)
        wr(sawd_pkg::CTRL_ADDR, 8'h80);
        rdchk(sawd_pkg::CTRL_ADDR, 8'h90);
        wait_done(n);
        rdchk(sawd_pkg::RES_ADDR, 8'h5c);
        rdchk(sawd_pkg::CTRL_ADDR, 8'ha0);
        `CHK(track, 1'b1)
        wr(sawd_pkg::CTRL_ADDR, 8'h80);
        rdchk(sawd_pkg::CTRL_ADDR, 8'h80);
        for (int i = 0; i < 11; i++) begin
            wr(sawd_pkg::LOWER_ADDR, lo_t[i]);
            wr(sawd_pkg::UPPER_ADDR, up_t[i]);
            diff = d_t[i];
            level = lv_t[i];
            wr(sawd_pkg::CTRL_ADDR, 8'h80);
            wr(sawd_pkg::CTRL_ADDR, 8'h90);
            wait_done(n);
            `CHK(n, 8)
            `CHK(match, m_t[i])
            rdchk(sawd_pkg::RES_ADDR, lv_t[i] ^ {d_t[i], 7'h00});
        end
        rdchk(sawd_pkg::UPPER_ADDR, 8'h20);
        // match stays set through a non-matching result
        level = 8'h15;
        wr(sawd_pkg::CTRL_ADDR, 8'hb1);
        repeat (12) @(negedge core_clk);
        rdchk(sawd_pkg::RES_ADDR, 8'h15);
        `CHK(match, 1'b1)
        // every source in both track modes, divider field two (one SAR tick every three clocks)
        wr(sawd_pkg::CFG_ADDR, 8'h10);
        level = 8'h33;
        for (int tm = 0; tm < 2; tm++) begin
            for (int s = 0; s < 8; s++) begin
                k = (s > 3) ? 4 : s;
                wr(sawd_pkg::CTRL_ADDR, 8'h80 | 8'(tm << 6));
                wr(sawd_pkg::CTRL_ADDR, 8'h90 | 8'(tm << 6) | 8'(s << 1));
                if (s != 0) begin
                    for (int j = 1; j < 5; j++) begin
                        if (j != k) fire(j, 1'b0);
                    end
                    rdchk(sawd_pkg::CTRL_ADDR,
                          8'h80 | 8'(tm << 6) | 8'(s << 1));
                    `CHK(track, 1'(1 - tm))
                    fire(k, tm == 1 && k == 2);
                end
                wait_done(n);
                if (k == 2) `CHK(n >= 22 && n <= 30, 1'b1)
                else `CHK(n, (tm == 1) ? 33 : 24)
            end
        end
        wr(sawd_pkg::CTRL_ADDR, 8'h90);
        repeat (3) @(negedge core_clk);
        wr(sawd_pkg::CTRL_ADDR, 8'h00);
        `CHK(power_on, 1'b0)
        wr(sawd_pkg::CTRL_ADDR, 8'h10);
        repeat (30) @(negedge core_clk);
        rdchk(sawd_pkg::CTRL_ADDR, 8'h00);
        `CHK(done, 1'b0)
        report_and_stop();
    end
endmodule : test_sar_adc_control_window_detect
`default_nettype wire
